// ==== hw/dccp_pkg.sv ====
// Purpose: Shared constants for the converter code and calibration path.
// Assumes: 16-bit codes, eight channels in two groups, one offset converter per group.
// Notes: Offsets are word indices on the plain register port.
//
// Overview of operation
// - Correction off: input code goes to the 16-bit converter code unchanged in binary, MSB inverted in twos complement.
// - Correction on: code = input * (gain trim + 2^15) / 2^16 + signed zero trim.
// - Configuration gain select bit chooses amplifier gain six or four.
// - Dual supply: offset defaults 39322 (gain six), 43691 (gain four), 5-bit signed trim of -16 to +15 LSB.
// - Reset loads gain trims 32768, zero trims zero, input registers 0000h.
// - Format pin low means straight binary, high means twos complement, for inputs and offsets.
// - Binary 8000h is zero; twos complement 0000h is zero, 8000h negative full scale.
// - Gain trim is always straight binary, zero trim always twos complement.
// - Reads return data in the format in which it was written.
// - A gain select change reloads the offset codes with the new gain default.
// - Reset loads offset codes with the gain-six default plus factory trim, whatever the data format.
// - Two 16-bit offset converters, one per group, powered down in single supply.
// - Single supply keeps both offset converters powered down.
// - Channels 0-3 with offset A are group A, channels 4-7 with offset B group B.
// - Correction enable resets to zero; then trim writes only store values.
// - Reset loads channel codes 8000h or 0000h from the reset value select pin.
package dccp_pkg;
   localparam int          CODE_W       = 16;
   localparam int          NUM_CH       = 8;
   localparam int          NUM_GRP      = 2;
   localparam int          CH_PER_GRP   = 4;
   localparam int          ADDR_W       = 6;
   // Register word indices
   localparam logic [5:0]  BASE_INPUT   = 6'h00;
   localparam logic [5:0]  BASE_GTRIM   = 6'h08;
   localparam logic [5:0]  BASE_ZTRIM   = 6'h10;
   localparam logic [5:0]  BASE_CHAN    = 6'h18;
   localparam logic [5:0]  ADDR_CFG     = 6'h20;
   localparam logic [5:0]  ADDR_OFFS_A  = 6'h21;
   localparam logic [5:0]  ADDR_OFFS_B  = 6'h22;
   // Configuration field positions
   localparam int          CFG_CE_BIT   = 0;
   localparam int          CFG_GSEL_BIT = 1;
   localparam logic        RST_CE       = 1'b0;
   localparam logic        RST_GSEL     = 1'b1;
   // Reset values and code constants
   localparam logic [15:0] RST_GTRIM    = 16'h8000;
   localparam logic [15:0] RST_ZTRIM    = 16'h0000;
   localparam logic [15:0] RST_INPUT    = 16'h0000;
   localparam logic [15:0] CODE_MID     = 16'h8000;
   localparam logic [15:0] CODE_LOW     = 16'h0000;
   localparam logic [15:0] CODE_TOP     = 16'hffff;
   localparam logic [15:0] FMT_FLIP     = 16'h8000;
   localparam logic [16:0] GAIN_BIAS    = 17'h08000;
   localparam logic [15:0] OFFS_DEF_G6  = 16'h999a;
   localparam logic [15:0] OFFS_DEF_G4  = 16'haaab;
   localparam int          TRIM_W       = 5;
endpackage : dccp_pkg

// ==== hw/dccp_corr.sv ====
// Purpose: Shared correction arithmetic: gain trim multiply, zero trim add, clamp.
// Assumes: Code input already in straight binary; gain trim binary, zero trim signed.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module dccp_corr (
   input  wire logic        [15:0] code_in,  // Straight binary input code
   input  wire logic        [15:0] gain_in,  // Gain trim, straight binary
   input  wire logic        [15:0] zero_in,  // Zero trim, twos complement
   output logic             [15:0] res_out,  // Clamped converter code
   output logic signed      [18:0] sum_out   // Unclamped sum, for checking
);
   logic [16:0] gain_full;
   logic [32:0] prod;
   logic [16:0] scaled;

   always_comb begin
      gain_full = {1'b0, gain_in} + dccp_pkg::GAIN_BIAS;
      prod      = {17'h00000, code_in} * {16'h0000, gain_full};
      scaled    = prod[32:16];
      sum_out   = $signed({2'b00, scaled}) + $signed({{3{zero_in[15]}}, zero_in});
      // Clamp rather than wrap, so an aggressive trim never folds the ramp over
      if (sum_out < 0) begin
         res_out = dccp_pkg::CODE_LOW;
      end else if (sum_out > $signed({3'b000, dccp_pkg::CODE_TOP})) begin
         res_out = dccp_pkg::CODE_TOP;
      end else begin
         res_out = sum_out[15:0];
      end
   end
endmodule : dccp_corr

// ==== hw/dccp_top.sv ====
// Purpose: Register file and code path of an octal 16-bit converter with user calibration.
// Assumes: Straps and the supply mode pin are static and asynchronous; reset held three edges.
// Notes: Channel and offset codes are held internally as straight binary converter codes.
`timescale 1ns/1ps
module dccp_top #(
   parameter logic signed [4:0] TRIM_A_G6 = 5'sd0,  // Factory trim, group A, gain six
   parameter logic signed [4:0] TRIM_A_G4 = 5'sd0,  // Factory trim, group A, gain four
   parameter logic signed [4:0] TRIM_B_G6 = 5'sd0,  // Factory trim, group B, gain six
   parameter logic signed [4:0] TRIM_B_G4 = 5'sd0   // Factory trim, group B, gain four
) (
   input  wire logic          ref_clk_in,               // 100 MHz clock
   input  wire logic          reset_in,                 // Synchronous reset, active high
   input  wire logic [5:0]    addr_in,                  // Register word index
   input  wire logic [15:0]   wr_data_in,               // Write data
   input  wire logic          wr_in,                    // Write strobe
   input  wire logic          rd_in,                    // Read strobe
   output logic      [15:0]   rd_data_out,              // Read data, cycle after strobe
   input  wire logic          format_select_pin_in,     // High: twos complement
   input  wire logic          reset_value_select_pin_in,// High: reset to zero output
   input  wire logic          single_supply_in,         // High: single-supply operation
   output logic      [127:0]  chan_code_out,            // Eight converter codes, ch0 low
   output logic      [31:0]   offset_code_out,          // Offset A low, offset B high
   output logic               offset_pd_out,            // Offset converters powered down
   output logic               gain_six_out              // High: gain six, low: gain four
);
   typedef struct packed {
      logic             fmt_s1;
      logic             fmt_s2;
      logic             rsel_s1;
      logic             rsel_s2;
      logic             ss_s1;
      logic             ss_s2;
      logic [7:0][15:0] inp;
      logic [7:0][15:0] gtrim;
      logic [7:0][15:0] ztrim;
      logic [7:0][15:0] chan;
      logic [1:0][15:0] offs;
      logic             correction_enable_bit;
      logic             gsel;
      logic             pd;
      logic [15:0]      rd_data;
   } dccp_state_t;

   dccp_state_t s;
   dccp_state_t next_s;

   logic [15:0]        flip;
   logic [2:0]         ch;
   logic               hit_inp;
   logic               hit_gtrim;
   logic               hit_ztrim;
   logic               hit_chan;
   logic [15:0]        corr_code;
   logic [15:0]        corr_gain;
   logic [15:0]        corr_zero;
   logic [15:0]        corr_res;
   logic signed [18:0] corr_sum;

   // Default offset code for one group and gain, straight binary
   function automatic logic [15:0] dccp_offs_def(input logic grp, input logic g6);
      logic signed [4:0] t;
      t = grp ? (g6 ? TRIM_B_G6 : TRIM_B_G4) : (g6 ? TRIM_A_G6 : TRIM_A_G4);
      return (g6 ? dccp_pkg::OFFS_DEF_G6 : dccp_pkg::OFFS_DEF_G4) + {{11{t[4]}}, t};
   endfunction : dccp_offs_def

   always_comb begin
      flip      = s.fmt_s2 ? dccp_pkg::FMT_FLIP : 16'h0000;
      ch        = addr_in[2:0];
      hit_inp   = addr_in[5:3] == dccp_pkg::BASE_INPUT[5:3];
      hit_gtrim = addr_in[5:3] == dccp_pkg::BASE_GTRIM[5:3];
      hit_ztrim = addr_in[5:3] == dccp_pkg::BASE_ZTRIM[5:3];
      hit_chan  = addr_in[5:3] == dccp_pkg::BASE_CHAN[5:3];
      // Feed the engine with the value being written so the result lands in the same cycle
      corr_code = ((wr_in && hit_inp) ? wr_data_in : s.inp[ch]) ^ flip;
      corr_gain = (wr_in && hit_gtrim) ? wr_data_in : s.gtrim[ch];
      corr_zero = (wr_in && hit_ztrim) ? wr_data_in : s.ztrim[ch];
   end

   dccp_corr u_corr (
      .code_in (corr_code),
      .gain_in (corr_gain),
      .zero_in (corr_zero),
      .res_out (corr_res),
      .sum_out (corr_sum)
   );

   always_comb begin
      next_s         = s;
      next_s.fmt_s1  = format_select_pin_in;
      next_s.fmt_s2  = s.fmt_s1;
      next_s.rsel_s1 = reset_value_select_pin_in;
      next_s.rsel_s2 = s.rsel_s1;
      next_s.ss_s1   = single_supply_in;
      next_s.ss_s2   = s.ss_s1;
      next_s.pd      = s.ss_s2;
      next_s.rd_data = 16'h0000;
      if (reset_in) begin
         for (int i = 0; i < dccp_pkg::NUM_CH; i++) begin
            next_s.inp[i]   = dccp_pkg::RST_INPUT;
            next_s.gtrim[i] = dccp_pkg::RST_GTRIM;
            next_s.ztrim[i] = dccp_pkg::RST_ZTRIM;
            // Select high parks at bipolar zero, low at negative full scale
            next_s.chan[i]  = s.rsel_s2 ? dccp_pkg::CODE_MID : dccp_pkg::CODE_LOW;
         end
         next_s.offs[0]               = dccp_offs_def(1'b0, dccp_pkg::RST_GSEL);
         next_s.offs[1]               = dccp_offs_def(1'b1, dccp_pkg::RST_GSEL);
         next_s.correction_enable_bit = dccp_pkg::RST_CE;
         next_s.gsel                  = dccp_pkg::RST_GSEL;
      end else if (wr_in) begin
         if (hit_inp) begin
            next_s.inp[ch] = wr_data_in;
            if (s.correction_enable_bit) begin
               next_s.chan[ch] = corr_res;
            end else begin
               next_s.chan[ch] = wr_data_in ^ flip;
            end
         end else if (hit_gtrim) begin
            next_s.gtrim[ch] = wr_data_in;
            if (s.correction_enable_bit) begin
               next_s.chan[ch] = corr_res;
            end
         end else if (hit_ztrim) begin
            next_s.ztrim[ch] = wr_data_in;
            if (s.correction_enable_bit) begin
               next_s.chan[ch] = corr_res;
            end
         end else if (addr_in == dccp_pkg::ADDR_CFG) begin
            next_s.correction_enable_bit = wr_data_in[dccp_pkg::CFG_CE_BIT];
            next_s.gsel                  = wr_data_in[dccp_pkg::CFG_GSEL_BIT];
            // A gain change throws away any custom offset; software must rewrite it
            if (wr_data_in[dccp_pkg::CFG_GSEL_BIT] != s.gsel) begin
               next_s.offs[0] = dccp_offs_def(1'b0, wr_data_in[dccp_pkg::CFG_GSEL_BIT]);
               next_s.offs[1] = dccp_offs_def(1'b1, wr_data_in[dccp_pkg::CFG_GSEL_BIT]);
            end
         end else if (addr_in == dccp_pkg::ADDR_OFFS_A) begin
            next_s.offs[0] = wr_data_in ^ flip;
         end else if (addr_in == dccp_pkg::ADDR_OFFS_B) begin
            next_s.offs[1] = wr_data_in ^ flip;
         end
      end else if (rd_in) begin
         if (hit_inp) begin
            next_s.rd_data = s.inp[ch];
         end else if (hit_gtrim) begin
            next_s.rd_data = s.gtrim[ch];
         end else if (hit_ztrim) begin
            next_s.rd_data = s.ztrim[ch];
         end else if (hit_chan) begin
            next_s.rd_data = s.chan[ch] ^ flip;
         end else if (addr_in == dccp_pkg::ADDR_CFG) begin
            next_s.rd_data[dccp_pkg::CFG_CE_BIT]   = s.correction_enable_bit;
            next_s.rd_data[dccp_pkg::CFG_GSEL_BIT] = s.gsel;
         end else if (addr_in == dccp_pkg::ADDR_OFFS_A) begin
            next_s.rd_data = s.offs[0] ^ flip;
         end else if (addr_in == dccp_pkg::ADDR_OFFS_B) begin
            next_s.rd_data = s.offs[1] ^ flip;
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      s <= next_s;
   end

   assign rd_data_out     = s.rd_data;
   assign chan_code_out   = s.chan;
   // Offset A sits in the low half, serving channels 0-3; offset B serves 4-7
   assign offset_code_out = s.offs;
   assign offset_pd_out   = s.pd;
   assign gain_six_out    = s.gsel;

   // Checks
   AST_PASS: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (wr_in && hit_inp && !s.correction_enable_bit)
      |=> s.chan[$past(ch)] == ($past(wr_data_in) ^ flip))
      else $error("passthrough code mismatch");

   AST_CORR: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (wr_in && (hit_inp || hit_gtrim || hit_ztrim) && s.correction_enable_bit)
      |=> s.chan[$past(ch)] == $past(corr_res))
      else $error("corrected code not loaded");

   AST_GAIN: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (wr_in && addr_in == dccp_pkg::ADDR_CFG)
      |=> gain_six_out == $past(wr_data_in[dccp_pkg::CFG_GSEL_BIT]))
      else $error("gain select not applied");

   AST_OFFS_RELOAD: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (wr_in && addr_in == dccp_pkg::ADDR_CFG && wr_data_in[dccp_pkg::CFG_GSEL_BIT] != s.gsel)
      |=> offset_code_out[15:0] == (s.gsel ? dccp_pkg::OFFS_DEF_G6 : dccp_pkg::OFFS_DEF_G4)
          + {{11{TRIM_A_G6[4]}}, TRIM_A_G6} * s.gsel + {{11{TRIM_A_G4[4]}}, TRIM_A_G4} * !s.gsel)
      else $error("offset default not reloaded");

   AST_RESET_VAL: assert property (@(posedge ref_clk_in)
      $past(reset_in) && !reset_in |-> s.gtrim[7] == dccp_pkg::RST_GTRIM && s.ztrim[0] == 16'h0000
         && s.inp[3] == 16'h0000 && !s.correction_enable_bit)
      else $error("trim reset values wrong");

   AST_RESET_CODE: assert property (@(posedge ref_clk_in)
      $past(reset_in) && !reset_in
      |-> chan_code_out[15:0] == (s.rsel_s2 ? 16'h8000 : 16'h0000)
          && offset_code_out[31:16] == dccp_offs_def(1'b1, 1'b1))
      else $error("reset codes wrong");

   AST_ZERO_MAP: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (wr_in && hit_inp && !s.correction_enable_bit && wr_data_in == 16'h0000 && s.fmt_s2)
      ##1 s.fmt_s2 |-> s.chan[$past(ch, 1)] == 16'h8000 || $past(ch, 1) != $past(ch, 2))
      else $error("twos complement zero not at midscale");

   AST_READBACK: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (wr_in && hit_gtrim) ##1 (rd_in && addr_in == $past(addr_in))
      |=> rd_data_out == $past(wr_data_in, 2))
      else $error("read back differs from write");

   AST_PD: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      s.ss_s2 [*2] |=> offset_pd_out)
      else $error("offset converters not powered down");

   AST_SAT: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (corr_sum < 0 |-> corr_res == 16'h0000) and (corr_sum > 19'sd65535 |-> corr_res == 16'hffff))
      else $error("corrected code wrapped");

   AST_RD_ONE: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      !rd_in |=> rd_data_out == 16'h0000)
      else $error("read data held beyond one cycle");

   // Readback checks: each register returns the format it was written in
   AST_RD_INP: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (rd_in && hit_inp) |=> rd_data_out == $past(s.inp[ch]))
      else $error("input register readback wrong");

   AST_RD_GTRIM: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (rd_in && hit_gtrim) |=> rd_data_out == $past(s.gtrim[ch]))
      else $error("gain trim readback wrong");

   AST_RD_ZTRIM: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (rd_in && hit_ztrim) |=> rd_data_out == $past(s.ztrim[ch]))
      else $error("zero trim readback wrong");

   AST_RD_CHAN: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (rd_in && hit_chan) |=> rd_data_out == ($past(s.chan[ch]) ^ $past(flip)))
      else $error("channel code readback wrong");

   AST_RD_OFFS_A: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (rd_in && addr_in == dccp_pkg::ADDR_OFFS_A) |=> rd_data_out == ($past(s.offs[0]) ^ $past(flip)))
      else $error("offset A readback wrong");

   AST_RD_OFFS_B: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (rd_in && addr_in == dccp_pkg::ADDR_OFFS_B) |=> rd_data_out == ($past(s.offs[1]) ^ $past(flip)))
      else $error("offset B readback wrong");

   AST_RD_CFG: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (rd_in && addr_in == dccp_pkg::ADDR_CFG)
      |=> rd_data_out == {14'h0000, $past(s.gsel), $past(s.correction_enable_bit)})
      else $error("configuration readback wrong");

   // Write side: stores and the format flip on offsets
   AST_OFFS_A_WR: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (wr_in && addr_in == dccp_pkg::ADDR_OFFS_A)
      |=> offset_code_out[15:0] == ($past(wr_data_in) ^ $past(flip)))
      else $error("offset A write not stored");

   AST_OFFS_B_WR: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (wr_in && addr_in == dccp_pkg::ADDR_OFFS_B)
      |=> offset_code_out[31:16] == ($past(wr_data_in) ^ $past(flip)) && $stable(offset_code_out[15:0]))
      else $error("offset B write leaked into group A");

   AST_INP_STORE: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (wr_in && hit_inp) |=> s.inp[$past(ch)] == $past(wr_data_in))
      else $error("input register not stored");

   AST_GTRIM_STORE: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (wr_in && hit_gtrim) |=> s.gtrim[$past(ch)] == $past(wr_data_in))
      else $error("gain trim not stored");

   AST_ZTRIM_STORE: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (wr_in && hit_ztrim) |=> s.ztrim[$past(ch)] == $past(wr_data_in))
      else $error("zero trim not stored");

   AST_CE_STORE: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (wr_in && (hit_gtrim || hit_ztrim) && !s.correction_enable_bit) |=> $stable(chan_code_out))
      else $error("trim write moved a code with correction off");

   AST_CHAN_RO: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (wr_in && hit_chan) |=> $stable(chan_code_out))
      else $error("channel code range is not read-only");

   AST_BTC_FLIP: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (wr_in && hit_inp && !s.correction_enable_bit && s.fmt_s2)
      |=> s.chan[$past(ch)][15] != $past(wr_data_in[15]))
      else $error("twos complement input not flipped");

   // Gain and offset housekeeping
   AST_NO_RELOAD: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (wr_in && addr_in == dccp_pkg::ADDR_CFG && wr_data_in[dccp_pkg::CFG_GSEL_BIT] == s.gsel)
      |=> $stable(offset_code_out))
      else $error("offset reloaded without a gain change");

   AST_GAIN_HOLD: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      !(wr_in && addr_in == dccp_pkg::ADDR_CFG) |=> $stable(gain_six_out))
      else $error("gain select moved without a write");

   AST_RESET_OFFS: assert property (@(posedge ref_clk_in)
      $past(reset_in) && !reset_in
      |-> offset_code_out[15:0] == dccp_offs_def(1'b0, 1'b1) && gain_six_out)
      else $error("offset A reset default wrong");

   AST_PD_OFF: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      !s.ss_s2 [*2] |=> !offset_pd_out)
      else $error("offset converters powered down in dual supply");

   // In range the result must be the plain sum, not a clamp
   AST_CORR_RANGE: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (corr_sum >= 0 && corr_sum <= 19'sd65535) |-> corr_res == corr_sum[15:0])
      else $error("in-range corrected code altered");

   COV_CORR: cover property (@(posedge ref_clk_in) disable iff (reset_in)
      wr_in && hit_inp && s.correction_enable_bit);
   COV_GAIN_CHG: cover property (@(posedge ref_clk_in) disable iff (reset_in)
      wr_in && addr_in == dccp_pkg::ADDR_CFG && wr_data_in[dccp_pkg::CFG_GSEL_BIT] != s.gsel);
   COV_SAT: cover property (@(posedge ref_clk_in) disable iff (reset_in)
      wr_in && s.correction_enable_bit && corr_sum > 19'sd65535);
   COV_BTC: cover property (@(posedge ref_clk_in) disable iff (reset_in)
      wr_in && hit_inp && s.fmt_s2);
   COV_RD_BACK: cover property (@(posedge ref_clk_in) disable iff (reset_in)
      (wr_in && hit_gtrim) ##1 (rd_in && hit_gtrim));
endmodule : dccp_top

// ==== bench/dccp_host.sv ====
// Purpose: Host processor model driving the plain register port of the code path.
// Assumes: Read data stand only in the cycle after the read strobe.
// Notes: Strobes last one cycle; each task ends one step past its closing edge.
`timescale 1ns/1ps
module dccp_host (
   input  wire logic        clk_in,      // Bus clock
   input  wire logic [15:0] rd_data_in,  // Read data from the device
   output logic      [5:0]  addr_out,    // Register word index
   output logic      [15:0] wr_data_out, // Write data
   output logic             wr_out,      // Write strobe
   output logic             rd_out       // Read strobe
);
   initial begin
      addr_out    = 6'h00;
      wr_data_out = 16'h0000;
      wr_out      = 1'b0;
      rd_out      = 1'b0;
   end

   task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr_out    <= a;
      wr_data_out <= d;
      wr_out      <= 1'b1;
      @(posedge clk_in);
      wr_out      <= 1'b0;
      // Inverted data after release, so stale values are never mistaken for live ones
      wr_data_out <= ~d;
      #1;
   endtask : wr_reg

   // Write then read the same word with no gap between the strobes
   task automatic wr_rd(input logic [5:0] a, input logic [15:0] d, output logic [15:0] q);
      @(posedge clk_in);
      addr_out    <= a;
      wr_data_out <= d;
      wr_out      <= 1'b1;
      @(posedge clk_in);
      wr_out      <= 1'b0;
      wr_data_out <= ~d;
      rd_out      <= 1'b1;
      @(posedge clk_in);
      rd_out      <= 1'b0;
      #1;
      q = rd_data_in;
   endtask : wr_rd

   task automatic rd_reg(input logic [5:0] a, output logic [15:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out   <= 1'b1;
      @(posedge clk_in);
      rd_out   <= 1'b0;
      #1;
      d = rd_data_in;
   endtask : rd_reg
endmodule : dccp_host

// ==== bench/dac_code_calibration_path_test.sv ====
// Purpose: Self-checking bench for the converter code and calibration path.
// Assumes: Factory trims left at zero, so offset defaults are the nominal codes.
// Notes: The whole sequence runs once per data format, each after its own reset.
`timescale 1ns/1ps
module dac_code_calibration_path_test;
   logic         ref_clk_in, reset_in, fmt, rsel, single, wr, rd, pd, g6;
   logic [5:0]   addr;
   logic [15:0]  wdata, rdata, flip, v, g, z, i, keep;
   logic [127:0] chan;
   logic [31:0]  offs;
   logic [31:0]  seed = 32'h8c9e;
   int           bad_count = 0;
   int           n_checks = 0;

   dccp_top DUT (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .addr_in(addr), .wr_data_in(wdata),
      .wr_in(wr), .rd_in(rd), .rd_data_out(rdata), .format_select_pin_in(fmt),
      .reset_value_select_pin_in(rsel), .single_supply_in(single), .chan_code_out(chan),
      .offset_code_out(offs), .offset_pd_out(pd), .gain_six_out(g6));
   dccp_host h (.clk_in(ref_clk_in), .rd_data_in(rdata), .addr_out(addr), .wr_data_out(wdata),
      .wr_out(wr), .rd_out(rd));

   initial begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end

   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction : rnd

   // Corrected code from a straight binary input; clamps instead of wrapping
   function automatic logic [15:0] corr(input logic [15:0] ci, cg, cz);
      longint s;
      s = ((longint'(ci) * (longint'(cg) + 32768)) >>> 16) + longint'($signed(cz));
      return (s < 0) ? 16'h0000 : ((s > 65535) ? 16'hffff : 16'(s));
   endfunction : corr

   task automatic chk(input logic [15:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rdchk(input logic [5:0] a, input logic [15:0] exp);
      h.rd_reg(a, v);
      chk(v, exp);
   endtask : rdchk

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out

   task automatic run_all(input logic f, input logic rs);
      @(posedge ref_clk_in);
      reset_in <= 1'b1;
      fmt      <= f;
      rsel     <= rs;
      repeat (10) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      #1;
      flip = f ? 16'h8000 : 16'h0000;
      for (int k = 0; k < 8; k++) begin
         chk(chan[16*k +: 16], rs ? 16'h8000 : 16'h0000);
         rdchk(dccp_pkg::BASE_GTRIM + 6'(k), 16'h8000);
         rdchk(dccp_pkg::BASE_ZTRIM + 6'(k), 16'h0000);
         rdchk(dccp_pkg::BASE_INPUT + 6'(k), 16'h0000);
      end
      chk(offs[15:0], 16'h999a);
      chk(offs[31:16], 16'h999a);
      rdchk(dccp_pkg::ADDR_OFFS_A, 16'h999a ^ flip);
      chk({15'h0, g6}, 16'h0001);
      for (int k = 0; k < 8; k++) begin
         i = (k == 0) ? 16'hffff : ((k == 1) ? 16'h0000 : rnd());
         h.wr_reg(dccp_pkg::BASE_INPUT + 6'(k), i);
         chk(chan[16*k +: 16], i ^ flip);
         rdchk(dccp_pkg::BASE_CHAN + 6'(k), i);
      end
      keep = chan[15:0];
      h.wr_rd(dccp_pkg::BASE_GTRIM, 16'h1234, v);
      chk(v, 16'h1234);
      h.wr_reg(dccp_pkg::BASE_CHAN, 16'h5555);
      chk(chan[15:0], keep);
      rdchk(6'h3f, 16'h0000);
      h.wr_reg(dccp_pkg::ADDR_CFG, 16'h0003);
      rdchk(dccp_pkg::ADDR_CFG, 16'h0003);
      for (int k = 0; k < 8; k++) begin
         g = (k == 0) ? 16'hffff : rnd();
         z = (k == 0) ? 16'h7fff : ((k == 1) ? 16'h8000 : rnd());
         i = (k == 0) ? 16'hffff ^ flip : ((k == 1) ? flip : rnd());
         h.wr_reg(dccp_pkg::BASE_GTRIM + 6'(k), g);
         h.wr_reg(dccp_pkg::BASE_ZTRIM + 6'(k), z);
         h.wr_reg(dccp_pkg::BASE_INPUT + 6'(k), i);
         chk(chan[16*k +: 16], corr(i ^ flip, g, z));
         z = rnd();
         h.wr_reg(dccp_pkg::BASE_ZTRIM + 6'(k), z);
         chk(chan[16*k +: 16], corr(i ^ flip, g, z));
         rdchk(dccp_pkg::BASE_ZTRIM + 6'(k), z);
      end
      h.wr_reg(dccp_pkg::ADDR_OFFS_B, 16'h2222);
      chk(offs[31:16], 16'h2222 ^ flip);
      rdchk(dccp_pkg::ADDR_OFFS_B, 16'h2222);
      h.wr_reg(dccp_pkg::ADDR_CFG, 16'h0002);
      chk(offs[31:16], 16'h2222 ^ flip);
      h.wr_reg(dccp_pkg::ADDR_CFG, 16'h0000);
      chk({15'h0, g6}, 16'h0000);
      chk(offs[15:0], 16'haaab);
      chk(offs[31:16], 16'haaab);
      h.wr_reg(dccp_pkg::ADDR_CFG, 16'h0002);
      chk(offs[31:16], 16'h999a);
      @(posedge ref_clk_in);
      single <= 1'b1;
      repeat (6) @(posedge ref_clk_in);
      #1;
      chk({15'h0, pd}, 16'h0001);
      single <= 1'b0;
      repeat (6) @(posedge ref_clk_in);
      #1;
      chk({15'h0, pd}, 16'h0000);
   endtask : run_all

   initial begin
      reset_in = 1'b1;
      fmt      = 1'b0;
      rsel     = 1'b1;
      single   = 1'b0;
      run_all(1'b0, 1'b1);
      run_all(1'b1, 1'b0);
      close_out();
   end

   // The two passes need well under 10000 cycles
   initial begin
      #200us;
      bad_count++;
      close_out();
   end
endmodule : dac_code_calibration_path_test
